/* File: core/agc_pkg.sv */
// Shared constants, field layouts, timing figures and carrier types of the input gain controller.
package agc_pkg;

	// ---------------------------------------------------------------
	// Register map: indices, byte address is four times the index.
	// ---------------------------------------------------------------
	localparam int          ADDR_W       = 8;
	localparam logic [5:0]  IDX_LIMITS   = 6'h20;
	localparam logic [5:0]  IDX_TARGET   = 6'h21;
	localparam logic [5:0]  IDX_MODE     = 6'h22;
	localparam logic [5:0]  IDX_PGA      = 6'h23;
	localparam logic [5:0]  IDX_STATUS   = 6'h24;

	// Field positions and values after reset.
	localparam int          EN_BIT       = 8;
	localparam int          FLOOR_LSB    = 0;
	localparam int          CEIL_LSB     = 3;
	localparam int          LVL_LSB      = 0;
	localparam int          HOLD_LSB     = 4;
	localparam int          ZC_BIT       = 8;
	localparam int          MODE_BIT     = 8;
	localparam int          RISE_LSB     = 4;
	localparam int          FALL_LSB     = 0;
	localparam logic [8:0]  RST_LIMITS   = 9'h038;
	localparam logic [8:0]  RST_TARGET   = 9'h00B;
	localparam logic [8:0]  RST_MODE     = 9'h032;
	localparam logic [5:0]  RST_GAIN     = 6'h10;
	localparam logic [3:0]  RATE_CAP     = 4'hA;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam int          PEAK_SHIFT   = 8;

	// ---------------------------------------------------------------
	// Timing: figures as printed, cycle counts derived at 200 MHz.
	// ---------------------------------------------------------------
	localparam real CLK_NS       = 5.0;
	localparam real RISE_NORM_US = 410.0;
	localparam real FALL_NORM_US = 104.0;
	localparam real RISE_LIM_US  = 90.8;
	localparam real FALL_LIM_US  = 22.7;
	localparam real HOLD_BASE_MS = 2.665;
	localparam int  RISE_NORM_CYC = int'(RISE_NORM_US * 1000.0 / CLK_NS);
	localparam int  FALL_NORM_CYC = int'(FALL_NORM_US * 1000.0 / CLK_NS);
	localparam int  RISE_LIM_CYC  = int'(RISE_LIM_US * 1000.0 / CLK_NS);
	localparam int  FALL_LIM_CYC  = int'(FALL_LIM_US * 1000.0 / CLK_NS);
	localparam int  HOLD_BASE_CYC = int'(HOLD_BASE_MS * 1000000.0 / CLK_NS);

	// ---------------------------------------------------------------
	// Carrier types.
	// ---------------------------------------------------------------
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} agc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} agc_axil_rsp_t;

	typedef struct packed {
		logic [8:0]        limits;
		logic [8:0]        target;
		logic [8:0]        mode;
		logic [5:0]        gain;
		logic [5:0]        lim_start;
		logic              lim_act;
		logic              hold_done;
		logic              above;
		logic              pend_up;
		logic              pend_dn;
		logic              upd;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} agc_state_t;

	// Peak threshold for each target code, on a 16-bit full scale.
	function automatic logic [15:0] level_thresh(input logic [3:0] code);
		logic [15:0] t;
		t = 16'h0000;
		unique case (code)
			4'h0: t = 16'h04CF;
			4'h1: t = 16'h05B7;
			4'h2: t = 16'h06CB;
			4'h3: t = 16'h0812;
			4'h4: t = 16'h0998;
			4'h5: t = 16'h0B67;
			4'h6: t = 16'h0D8E;
			4'h7: t = 16'h101C;
			4'h8: t = 16'h1325;
			4'h9: t = 16'h16C2;
			4'hA: t = 16'h1B0C;
			4'hB: t = 16'h2026;
			4'hC: t = 16'h2635;
			4'hD: t = 16'h2D6A;
			4'hE: t = 16'h35FA;
			4'hF: t = 16'h4027;
		endcase
		return t;
	endfunction

	// Interval doubling with each code, saturating at the cap code.
	function automatic logic [31:0] rate_period(input logic [31:0] base, input logic [3:0] code);
		logic [3:0] c;
		c = (code > RATE_CAP) ? RATE_CAP : code;
		return base << c;
	endfunction

	// Merge a byte-strobed write into a 9-bit register.
	function automatic logic [8:0] wr9(input logic [8:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [8:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[8] = d[8];
		end
		return r;
	endfunction

endpackage

/* File: core/agc_peak_det.sv */
// Digital peak detector with zero-crossing flag for the input gain controller.
`timescale 1ns/10ps
`default_nettype none
module agc_peak_det #(
	parameter int SHIFT = agc_pkg::PEAK_SHIFT
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample_data,
	output logic      [15:0] peak,
	output logic             zero_cross
);

	typedef struct packed {
		logic [15:0] peak;
		logic        sign;
		logic        zc;
	} agc_pd_state_t;

	agc_pd_state_t st_ff;
	agc_pd_state_t nxt_st;
	logic [15:0]   mag;

	// Magnitude of the two's complement sample, with the most negative code saturated.
	always_comb begin
		nxt_st = st_ff;
		mag = sample_data[15] ? 16'(~sample_data + 16'h0001) : sample_data;
		if (mag[15]) begin
			mag = 16'h7FFF;
		end
		nxt_st.zc = 1'b0;
		// Fast attack, slow release, so short bursts still register.
		if (sample_valid) begin
			nxt_st.peak = (mag > st_ff.peak) ? mag : 16'(st_ff.peak - (st_ff.peak >> SHIFT));
			nxt_st.sign = sample_data[15];
			nxt_st.zc   = sample_data[15] != st_ff.sign;
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign peak       = st_ff.peak;
	assign zero_cross = st_ff.zc;

endmodule
`default_nettype wire

/* File: core/agc_step_timer.sv */
// Restartable interval timer that pulses once per programmed period.
`timescale 1ns/10ps
`default_nettype none
module agc_step_timer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        restart,
	input  wire logic [31:0] period,
	output logic             tick
);

	typedef struct packed {
		logic [31:0] cnt;
	} agc_tm_state_t;

	agc_tm_state_t st_ff;
	agc_tm_state_t nxt_st;

	// The tick is a handshake-style strobe, so it is left combinational.
	assign tick = !restart && (st_ff.cnt >= 32'(period - 32'h0000_0001));

	// Count up, wrap on each tick, hold at zero while restarted.
	always_comb begin
		nxt_st = st_ff;
		if (restart || tick) begin
			nxt_st.cnt = 32'h0000_0000;
		end else begin
			nxt_st.cnt = 32'(st_ff.cnt + 32'h0000_0001);
		end
	end

	// State register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

endmodule
`default_nettype wire

/* File: core/agc_gain_ctrl.sv */
// Automatic level control of the input PGA gain, with its AXI4-Lite register slave.
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module agc_gain_ctrl #(
	parameter int RISE_NORM_CYC = agc_pkg::RISE_NORM_CYC,
	parameter int FALL_NORM_CYC = agc_pkg::FALL_NORM_CYC,
	parameter int RISE_LIM_CYC  = agc_pkg::RISE_LIM_CYC,
	parameter int FALL_LIM_CYC  = agc_pkg::FALL_LIM_CYC,
	parameter int HOLD_BASE_CYC = agc_pkg::HOLD_BASE_CYC
) (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire agc_pkg::agc_axil_req_t axil_req,
	output agc_pkg::agc_axil_rsp_t      axil_rsp,
	input  wire logic                   sample_valid,
	input  wire logic [15:0]            sample_data,
	output logic      [5:0]             pga_gain,
	output logic                        pga_gain_update,
	output logic                        peak_above
);

	agc_pkg::agc_state_t st_ff;
	agc_pkg::agc_state_t nxt_st;

	logic [15:0] peak;
	logic        zc;
	logic        en;
	logic        lim;
	logic        zc_en;
	logic        above;
	logic [5:0]  floor_code;
	logic [5:0]  ceil_code;
	logic        step_run;
	logic        step_restart;
	logic        step_tick;
	logic [31:0] step_period;
	logic        hold_restart;
	logic        hold_tick;
	logic [31:0] hold_period;
	logic [3:0]  hold_code;
	logic        gate;
	logic        apply_up;
	logic        apply_dn;
	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        do_write;
	logic [5:0]  widx;
	logic [5:0]  ridx;

	// ---------------------------------------------------------------
	// Peak detection and interval timers.
	// ---------------------------------------------------------------
	agc_peak_det u_peak (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.sample_valid (sample_valid),
		.sample_data  (sample_data),
		.peak         (peak),
		.zero_cross   (zc)
	);

	agc_step_timer u_step (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (step_restart),
		.period  (step_period),
		.tick    (step_tick)
	);

	agc_step_timer u_hold (
		.aclk    (aclk),
		.aresetn (aresetn),
		.restart (hold_restart),
		.period  (hold_period),
		.tick    (hold_tick)
	);

	// Field decode of the three control registers.
	assign en         = st_ff.limits[agc_pkg::EN_BIT];
	assign lim        = st_ff.mode[agc_pkg::MODE_BIT];
	assign zc_en      = st_ff.target[agc_pkg::ZC_BIT];
	assign floor_code = {st_ff.limits[agc_pkg::FLOOR_LSB +: 3], 3'h0};
	assign ceil_code  = {st_ff.limits[agc_pkg::CEIL_LSB +: 3], 3'h7};
	assign hold_code  = st_ff.target[agc_pkg::HOLD_LSB +: 4];
	assign above      = peak > agc_pkg::level_thresh(st_ff.target[agc_pkg::LVL_LSB +: 4]);

	// Interval choice: limiter intervals are the shorter set for the same codes.
	always_comb begin
		if (above) begin
			step_period = agc_pkg::rate_period(lim ? 32'(FALL_LIM_CYC) : 32'(FALL_NORM_CYC),
				st_ff.mode[agc_pkg::FALL_LSB +: 4]);
		end else begin
			step_period = agc_pkg::rate_period(lim ? 32'(RISE_LIM_CYC) : 32'(RISE_NORM_CYC),
				st_ff.mode[agc_pkg::RISE_LSB +: 4]);
		end
	end

	// Hold interval: code 1 is the base, each code doubles up to the cap code, code 0 skips the wait.
	// The code is capped before the offset, so every code from the cap up gives the longest hold.
	assign hold_period  = (hold_code == 4'h0) ? 32'h0000_0001 :
		agc_pkg::rate_period(32'(HOLD_BASE_CYC),
			4'(((hold_code > agc_pkg::RATE_CAP) ? agc_pkg::RATE_CAP : hold_code) - 4'h1));
	assign hold_restart = !en || above;
	assign step_run     = en && (above || st_ff.hold_done);
	// A change of direction restarts the interval so a step never comes early.
	assign step_restart = !step_run || (above != st_ff.above);

	// Pending steps go out at once, or on the next zero crossing when gated.
	assign gate     = !zc_en || zc;
	// Steps start only inside the window and in the present direction; the clamp handles the rest.
	assign apply_dn = en && st_ff.pend_dn && gate && above &&
		(st_ff.gain > floor_code) && (st_ff.gain <= ceil_code);
	// No rise in the first limiter cycle, before the starting gain has been captured.
	assign apply_up = en && st_ff.pend_up && gate && !above && st_ff.hold_done &&
		(st_ff.gain < ceil_code) && (st_ff.gain >= floor_code) &&
		(!lim || (st_ff.lim_act && (st_ff.gain < st_ff.lim_start)));

	// ---------------------------------------------------------------
	// AXI4-Lite handshakes.
	// ---------------------------------------------------------------
	assign aw_hs    = axil_req.awvalid && !st_ff.aw_got && !st_ff.bvalid;
	assign w_hs     = axil_req.wvalid && !st_ff.w_got && !st_ff.bvalid;
	assign ar_hs    = axil_req.arvalid && !st_ff.rvalid;
	assign do_write = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	assign widx     = st_ff.awaddr[7:2];
	assign ridx     = axil_req.araddr[7:2];

	// Next state of the whole block.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.upd = 1'b0;
		nxt_st.above = above;

		// Hold wait completes after the interval below the threshold.
		if (!en || above) begin
			nxt_st.hold_done = 1'b0;
		end else if (hold_tick) begin
			nxt_st.hold_done = 1'b1;
		end

		// Each interval tick requests one step in the current direction.
		if (!en) begin
			nxt_st.pend_up = 1'b0;
			nxt_st.pend_dn = 1'b0;
		end else if (step_tick) begin
			nxt_st.pend_dn = above;
			nxt_st.pend_up = !above;
		end else if (gate) begin
			nxt_st.pend_up = 1'b0;
			nxt_st.pend_dn = 1'b0;
		end

		// One gain path for both modes; only the upward limit differs.
		if (apply_dn) begin
			nxt_st.gain = 6'(st_ff.gain - 6'h01);
			nxt_st.upd  = 1'b1;
		end else if (apply_up) begin
			nxt_st.gain = 6'(st_ff.gain + 6'h01);
			nxt_st.upd  = 1'b1;
		end

		// While running, pull the gain back inside the programmed window.
		if (en && !apply_dn && !apply_up) begin
			if (st_ff.gain > ceil_code) begin
				nxt_st.gain = ceil_code;
				nxt_st.upd  = 1'b1;
			end else if (st_ff.gain < floor_code) begin
				nxt_st.gain = floor_code;
				nxt_st.upd  = 1'b1;
			end
		end

		// Capture the starting gain on enable in limiter mode or at switchover.
		nxt_st.lim_act = en && lim;
		if (en && lim && !st_ff.lim_act) begin
			nxt_st.lim_start = st_ff.gain;
		end

		// Write channel: address and data are taken independently.
		if (aw_hs) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axil_req.awaddr;
		end
		if (w_hs) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = axil_req.wdata;
			nxt_st.wstrb = axil_req.wstrb;
		end
		if (do_write) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = agc_pkg::RESP_OKAY;
			unique case (widx)
				agc_pkg::IDX_LIMITS: nxt_st.limits = agc_pkg::wr9(st_ff.limits, st_ff.wdata, st_ff.wstrb);
				agc_pkg::IDX_TARGET: nxt_st.target = agc_pkg::wr9(st_ff.target, st_ff.wdata, st_ff.wstrb);
				agc_pkg::IDX_MODE:   nxt_st.mode   = agc_pkg::wr9(st_ff.mode, st_ff.wdata, st_ff.wstrb);
				agc_pkg::IDX_PGA: begin
					// Software owns the gain only while the controller is off.
					if (!en && st_ff.wstrb[0]) begin
						nxt_st.gain = st_ff.wdata[5:0];
						nxt_st.upd  = 1'b1;
					end
				end
				agc_pkg::IDX_STATUS: nxt_st.bresp = agc_pkg::RESP_OKAY;
				default:             nxt_st.bresp = agc_pkg::RESP_SLVERR;
			endcase
		end
		if (st_ff.bvalid && axil_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// Read channel: answer one cycle after the address is taken.
		if (ar_hs) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = agc_pkg::RESP_OKAY;
			nxt_st.rdata  = 32'h0000_0000;
			unique case (ridx)
				agc_pkg::IDX_LIMITS: nxt_st.rdata = {23'h000000, st_ff.limits};
				agc_pkg::IDX_TARGET: nxt_st.rdata = {23'h000000, st_ff.target};
				agc_pkg::IDX_MODE:   nxt_st.rdata = {23'h000000, st_ff.mode};
				agc_pkg::IDX_PGA:    nxt_st.rdata = {26'h0000000, st_ff.gain};
				agc_pkg::IDX_STATUS: nxt_st.rdata = {20'h00000, st_ff.lim_start, 3'h0, st_ff.lim_act,
					st_ff.hold_done, st_ff.above};
				default:             nxt_st.rresp = agc_pkg::RESP_SLVERR;
			endcase
		end else if (st_ff.rvalid && axil_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// State register with documented reset values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff        <= '0;
			st_ff.limits <= agc_pkg::RST_LIMITS;
			st_ff.target <= agc_pkg::RST_TARGET;
			st_ff.mode   <= agc_pkg::RST_MODE;
			st_ff.gain   <= agc_pkg::RST_GAIN;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs.
	assign pga_gain         = st_ff.gain;
	assign pga_gain_update  = st_ff.upd;
	assign peak_above       = st_ff.above;
	assign axil_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
	assign axil_rsp.wready  = !st_ff.w_got && !st_ff.bvalid;
	assign axil_rsp.bvalid  = st_ff.bvalid;
	assign axil_rsp.bresp   = st_ff.bresp;
	assign axil_rsp.arready = !st_ff.rvalid;
	assign axil_rsp.rvalid  = st_ff.rvalid;
	assign axil_rsp.rdata   = st_ff.rdata;
	assign axil_rsp.rresp   = st_ff.rresp;

	// ---------------------------------------------------------------
	// Assertions.
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_step_down;
		apply_dn ##1 1'b1;
	endsequence

	sequence s_write_pair;
		st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
	endsequence

	a_fall_step: assert property (s_step_down |-> pga_gain == 6'($past(pga_gain) - 6'h01))
		else $error("gain did not fall by one step");
	a_rise_step: assert property (apply_up |=> pga_gain == 6'($past(pga_gain) + 6'h01))
		else $error("gain did not rise by one step");
	a_floor_kept: assert property (en && floor_code <= ceil_code |=> pga_gain >= $past(floor_code))
		else $error("gain below floor");
	a_ceiling_kept: assert property (en |=> pga_gain <= $past(ceil_code))
		else $error("gain above ceiling");
	a_off_holds: assert property (!en && !do_write |=> $stable(pga_gain))
		else $error("gain moved while disabled");
	a_limiter_cap: assert property (st_ff.lim_act && pga_gain > $past(pga_gain) |->
		pga_gain <= st_ff.lim_start || pga_gain == $past(floor_code))
		else $error("limiter raised gain past start");
	a_zc_gate: assert property (zc_en && (apply_up || apply_dn) |-> zc && $past(sample_valid))
		else $error("gain changed away from zero crossing");
	a_hold_first: assert property (apply_up |-> st_ff.hold_done && !above)
		else $error("gain rose before hold time");
	a_step_paced: assert property (step_tick |=> ##[0:2] !step_tick)
		else $error("step interval too short");
	a_write_resp: assert property (s_write_pair |=> axil_rsp.bvalid [*1] ##0 !axil_rsp.awready)
		else $error("write not answered");
	a_read_resp: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("read not answered");

endmodule
`default_nettype wire

/* File: testbench/agc_pga_model.sv */
// Behavioural model of the input PGA and ADC that feed the gain controller.
`timescale 1ns/10ps
`default_nettype none
module agc_pga_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [5:0]  pga_gain,
	input  wire logic        pga_gain_update,
	input  wire logic [14:0] amp,
	input  wire logic        swing,
	output logic             sample_valid,
	output logic      [15:0] sample_data,
	output logic      [5:0]  gain_ff
);
	logic [1:0] div_ff;
	logic       neg_ff;
	// One sample every fourth cycle; without swing the sign stays put, so no crossing occurs.
	always_ff @(posedge aclk) begin
		div_ff <= aresetn ? div_ff + 2'h1 : 2'h0;
		neg_ff <= aresetn && (neg_ff ^ (swing && div_ff == 2'h3));
		if (!aresetn || pga_gain_update) begin
			gain_ff <= aresetn ? pga_gain : 6'h10;
		end
	end
	// Between samples the bus shows the inverse, so stale data never looks valid.
	assign sample_valid = (div_ff == 2'h3);
	assign sample_data  = (neg_ff ? -{1'b0, amp} : {1'b0, amp}) ^ {16{!sample_valid}};
endmodule
`default_nettype wire

/* File: testbench/agc_gain_ctrl_bench.sv */
// Self-checking bench for the input gain controller and its PGA model.
`timescale 1ns/10ps
`default_nettype none
module agc_gain_ctrl_bench;
	localparam logic [7:0] A_LIM = {agc_pkg::IDX_LIMITS, 2'b00};
	localparam logic [7:0] A_TGT = {agc_pkg::IDX_TARGET, 2'b00};
	localparam logic [7:0] A_MOD = {agc_pkg::IDX_MODE, 2'b00};
	localparam logic [7:0] A_PGA = {agc_pkg::IDX_PGA, 2'b00};
	localparam logic [1:0] OK    = agc_pkg::RESP_OKAY;
	localparam logic [1:0] SE    = agc_pkg::RESP_SLVERR;
	logic                   aclk    = 1'b0;
	logic                   aresetn = 1'b0;
	agc_pkg::agc_axil_req_t rq      = '0;
	agc_pkg::agc_axil_rsp_t rs;
	logic                   sv;
	logic [15:0]            sd;
	logic [5:0]             gain;
	logic [5:0]             held;
	logic [5:0]             gmax;
	logic                   upd;
	logic                   above;
	logic [14:0]            amp     = 15'h0100;
	logic                   swing   = 1'b1;
	int                     err_count = 0;
	int                     checked   = 0;
	int                     n1;
	int                     n2;
	logic [3:0]             lv [3]  = '{4'hF, 4'hB, 4'h0};
	logic [14:0]            lo [3]  = '{15'h3800, 15'h1C00, 15'h0400};
	logic [14:0]            hi [3]  = '{15'h4800, 15'h2400, 15'h0580};
	// Short step intervals keep the run brief; every expectation below uses these figures.
	agc_gain_ctrl #(.RISE_NORM_CYC(40), .FALL_NORM_CYC(10), .RISE_LIM_CYC(8), .FALL_LIM_CYC(4),
		.HOLD_BASE_CYC(20)) dut (.aclk(aclk), .aresetn(aresetn), .axil_req(rq), .axil_rsp(rs),
		.sample_valid(sv), .sample_data(sd), .pga_gain(gain), .pga_gain_update(upd),
		.peak_above(above));
	agc_pga_model pga (.aclk(aclk), .aresetn(aresetn), .pga_gain(gain), .pga_gain_update(upd),
		.amp(amp), .swing(swing), .sample_valid(sv), .sample_data(sd), .gain_ff(held));
	// Clock at 200 MHz.
	always #2.5 aclk = ~aclk;
	task automatic final_report();
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic fail_wait();
		err_count++;
		$display("Error at %0t: wait ran out", $time);
		final_report();
	endtask
	// One register access; each channel is released only after the edge that takes it.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic        aw, wd, ar, done;
		logic [31:0] q;
		logic [1:0]  rp;
		int          n;
		n = 0;
		done = 1'b0;
		@(posedge aclk);
		rq.awvalid <= w;
		rq.wvalid <= w;
		rq.bready <= w;
		rq.arvalid <= !w;
		rq.rready <= !w;
		rq.awaddr <= a;
		rq.araddr <= a;
		rq.wdata <= d;
		rq.wstrb <= 4'hF;
		while (!done) begin
			@(negedge aclk);
			aw = rs.awready;
			wd = rs.wready;
			ar = rs.arready;
			done = w ? rs.bvalid : rs.rvalid;
			rp = w ? rs.bresp : rs.rresp;
			q = rs.rdata;
			n++;
			if (n > 100) fail_wait();
			@(posedge aclk);
			if (aw) rq.awvalid <= 1'b0;
			if (wd) rq.wvalid <= 1'b0;
			if (ar) rq.arvalid <= 1'b0;
		end
		rq.bready <= 1'b0;
		rq.rready <= 1'b0;
		chk({30'h0, rp}, {30'h0, er});
		if (!w) chk(q, d);
	endtask
	task automatic drive(input logic [14:0] a, input logic s);
		@(posedge aclk);
		amp <= a;
		swing <= s;
	endtask
	// Bounded wait for the gain (sel low) or the above flag (sel high) to reach a value.
	task automatic await(input logic sel, input logic [5:0] e, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
			if (n > lim) fail_wait();
		end while ((sel ? {5'h0, above} : gain) !== e);
		checked++;
	endtask
	// Counts gain updates and the highest gain seen over a window.
	task automatic watch(input int n, output int c);
		c = 0;
		gmax = gain;
		repeat (n) begin
			@(negedge aclk);
			c += int'(upd === 1'b1);
			if (gain > gmax) gmax = gain;
		end
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		xfer(1'b0, A_LIM, 32'h038, OK);
		xfer(1'b0, A_TGT, 32'h00B, OK);
		xfer(1'b0, A_MOD, 32'h032, OK);
		xfer(1'b0, A_PGA, 32'h010, OK);
		xfer(1'b0, 8'hFC, 32'h000, SE);
		xfer(1'b1, 8'hFC, 32'h1FF, SE);
		// Loud input while disabled must leave the gain alone.
		drive(15'h7000, 1'b1);
		watch(300, n1);
		chk(n1, 0);
		chk(above, 1);
		xfer(1'b1, A_PGA, 32'h005, OK);
		watch(4, n1);
		chk(gain, 6'h05);
		// Enable with floor code 2 and ceiling code 3 at the fastest rates.
		xfer(1'b1, A_MOD, 32'h000, OK);
		xfer(1'b1, A_LIM, 32'h11A, OK);
		watch(300, n1);
		chk(gain, 2 * 8);
		drive(15'h0100, 1'b1);
		await(1'b1, 6'h0, 4000);
		await(1'b0, 3 * 8 + 7, 2000);
		watch(200, n1);
		chk(gmax, 3 * 8 + 7);
		chk(held, 3 * 8 + 7);
		xfer(1'b1, A_PGA, 32'h03F, OK);
		chk(gain, 3 * 8 + 7);
		// Switch to limiter at gain 31, then open the ceiling: quiet input must not raise it.
		xfer(1'b1, A_MOD, 32'h100, OK);
		xfer(1'b1, A_LIM, 32'h138, OK);
		watch(400, n1);
		chk(gmax, 3 * 8 + 7);
		drive(15'h7000, 1'b1);
		await(1'b1, 6'h1, 50);
		watch(60, n1);
		xfer(1'b1, A_MOD, 32'h000, OK);
		watch(60, n2);
		chk(n1 >= 11 && n1 <= 16, 1);
		chk(n2 >= 4 && n2 <= 7, 1);
		// With crossing gate on and no sign change, no step may land.
		drive(15'h7000, 1'b0);
		// Let the last crossing from the swinging input pass before the gate opens.
		watch(8, n1);
		xfer(1'b1, A_TGT, 32'h10B, OK);
		watch(100, n1);
		chk(n1, 0);
		drive(15'h7000, 1'b1);
		watch(40, n2);
		chk(n2 > 0, 1);
		// Threshold codes at both ends and the default, with amplitudes either side.
		xfer(1'b1, A_LIM, 32'h038, OK);
		foreach (lv[i]) begin
			xfer(1'b1, A_TGT, {28'h0, lv[i]}, OK);
			drive(lo[i], 1'b1);
			await(1'b1, 6'h0, 4000);
			drive(hi[i], 1'b1);
			await(1'b1, 6'h1, 50);
		end
		// Status: peak above, no hold while off, limiter idle, start gain 31 kept from the switchover.
		xfer(1'b0, {agc_pkg::IDX_STATUS, 2'b00}, 32'h7C1, OK);
		final_report();
	end
endmodule
`default_nettype wire
